// ---- verilog/glue_pkg.sv ----
package glue_pkg;

	// sequencer state, bit order {a, b, c}; gray along the access path
	typedef enum logic [2:0]
	{
		SEQ_IDLE = 3'h6,  // a1 b1 c0, held while the address strobe is off
		SEQ_T1   = 3'h2,
		SEQ_T2   = 3'h0,
		SEQ_T3   = 3'h1,
		SEQ_T4   = 3'h3,
		SEQ_T5   = 3'h7,
		SEQ_T6   = 3'h5,
		SEQ_T7   = 3'h4
	} seq_state_t;

	// processor and peripheral pins after synchronisation, active high
	typedef struct packed
	{
		logic       address_strobe;
		logic       lower_byte_strobe;
		logic       read_not_write;
		logic       wait_count_select;
		logic       ack;
		logic [2:0] cpu_function_code;
	} cpu_pins_t;

	// strobes towards the peripheral and the processor, active high
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic dtack;
	} strobes_t;

	localparam int unsigned PIN_W         = 8;
	localparam int unsigned SYNC_STAGES   = 2;

	// bit positions inside the state word
	localparam int unsigned STATE_BIT_A   = 2;
	localparam int unsigned STATE_BIT_B   = 1;
	localparam int unsigned STATE_BIT_C   = 0;

	// function code seen during interrupt acknowledge
	localparam logic [2:0]  FC_IRQ_ACK    = 3'h7;

	// wait states inserted per access kind
	localparam logic [3:0]  WAITS_SHORT   = 4'h1;
	localparam logic [3:0]  WAITS_LONG    = 4'h2;
	localparam logic [3:0]  WAITS_IRQ_ACK = 4'h4;

	// strobe cycles before the first wait state counts
	localparam logic [3:0]  DTACK_BASE    = 4'h2;
	localparam logic [3:0]  CNT_MAX       = 4'hf;

	localparam cpu_pins_t   PINS_RESET    = '0;
	localparam strobes_t    STROBES_RESET = '0;

endpackage : glue_pkg

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync
	import glue_pkg::*;
(
	// clock, reset, enable
	input  wire logic             clk_sys_i,
	input  wire logic             sys_rst_i,
	input  wire logic             ce_i,
	// asynchronous pins and their synchronised copies
	input  wire logic [PIN_W-1:0] async_i,
	output logic      [PIN_W-1:0] sync_o
);

	logic [PIN_W-1:0] meta;
	logic [PIN_W-1:0] next_meta;
	logic [PIN_W-1:0] stable;
	logic [PIN_W-1:0] next_stable;

	// two flops per pin; meta feeds only the second stage
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++)
		begin : g_bit
			always_comb
			begin
				next_meta[gi]   = ce_i ? async_i[gi] : meta[gi];
				next_stable[gi] = ce_i ? meta[gi] : stable[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			meta   <= '0;
			stable <= '0;
		end
		else
		begin
			meta   <= next_meta;
			stable <= next_stable;
		end
	end

	assign sync_o = stable;

endmodule : pin_sync

// ---- verilog/cpu_peripheral_wait_state_glue.sv ----
// Behaviour
// - During interrupt acknowledge the peripheral read strobe is driven so the peripheral puts its vector on the data bus.
// - Ordinary accesses get one wait state with the select high and two with it low.
// - Interrupt acknowledge cycles are stretched by four wait states regardless of the select.
// - In acknowledge the read strobe follows the sequencer, and follows the byte strobe only while ack is also active.
// - The asserting edge of the read strobe is delayed so peripheral select settles first.
// - A delayed byte strobe is registered each clock and ordinary reads strobe on the byte strobe only while live and delayed copies are both active.
// - Read also strobes in state a0 b0 c1 with select high outside acknowledge, in a1 b0 during acknowledge, and whenever ack and byte strobe are both active.
// - State bit a sets on a and not b, on b and c, or with the address strobe off.
// - State bit b sets on a and not c, on c and not a, or with the address strobe off.
// - State bit c sets only with the address strobe on, and then on not a and not b, or on b and c.
`timescale 1ns/1ns
module cpu_peripheral_wait_state_glue
	import glue_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	// processor bus pins, active low strobes
	input  wire logic       address_strobe_n_i,
	input  wire logic       lower_byte_strobe_n_i,
	input  wire logic       read_not_write_i,
	input  wire logic [2:0] cpu_function_code_i,
	// wait count select pin, high gives one wait state outside interrupt acknowledge
	input  wire logic       wait_count_select_i,
	// external acknowledge, active low
	input  wire logic       ack_n_i,
	// peripheral strobes, active low
	output logic            peripheral_rd_n_o,
	output logic            peripheral_wr_n_o,
	// transfer acknowledge back to the processor, active low
	output logic            dtack_n_o,
	// acknowledge cycle in progress, active high
	output logic            irq_acknowledge_cycle_o,
	// sequencer state for observation
	output logic [2:0]      seq_state_o
);

	// synchronised pin copies
	logic [PIN_W-1:0] raw_pins;
	logic [PIN_W-1:0] sync_pins;
	cpu_pins_t        pins;

	// sequencer
	seq_state_t       state;
	seq_state_t       next_state;
	logic             delayed_byte_strobe;
	logic             next_delayed_byte_strobe;

	// wait counter
	logic [3:0]       wait_cnt;
	logic [3:0]       next_wait_cnt;
	logic [3:0]       waits_needed;

	// decoded cycle and strobes
	logic             irq_acknowledge_cycle;
	logic             next_irq_ack;
	logic             irq_ack;
	strobes_t         strobes;
	strobes_t         next_strobes;

	logic             st_a;
	logic             st_b;
	logic             st_c;

	// wait states for the current access kind
	function automatic logic [3:0] wait_states(input logic in_ack,
		input logic select_short);
		logic [3:0] n;
		n = WAITS_LONG;
		case ({in_ack, select_short})
			2'h0:    n = WAITS_LONG;   // select low: two waits
			2'h1:    n = WAITS_SHORT;  // select high: one wait
			2'h2:    n = WAITS_IRQ_ACK;
			2'h3:    n = WAITS_IRQ_ACK;
			default: n = WAITS_LONG;
		endcase
		return n;
	endfunction : wait_states

	// all strobes are inverted here so logic below works active high
	assign raw_pins = {~address_strobe_n_i,
		~lower_byte_strobe_n_i,
		read_not_write_i,
		wait_count_select_i,
		~ack_n_i,
		cpu_function_code_i};

	// pins come from the processor clock domain's far side: resync
	pin_sync u_pin_sync
	(
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.async_i   (raw_pins),
		.sync_o    (sync_pins)
	);

	assign pins = cpu_pins_t'(sync_pins);

	assign st_a = state[STATE_BIT_A];
	assign st_b = state[STATE_BIT_B];
	assign st_c = state[STATE_BIT_C];

	// acknowledge decode; gated by the strobe to avoid status glitches
	always_comb
	begin
		irq_acknowledge_cycle = pins.address_strobe &&
			(pins.cpu_function_code == FC_IRQ_ACK);
	end

	// sequencer next state and delayed byte strobe
	always_comb
	begin
		logic na;
		logic nb;
		logic nc;
		na = 1'b0;
		nb = 1'b0;
		nc = 1'b0;
		na = (st_a && !st_b) || (st_b && st_c) ||
			!pins.address_strobe;
		nb = (st_a && !st_c) || (!st_a && st_c) ||
			!pins.address_strobe;
		nc = pins.address_strobe &&
			((!st_a && !st_b) || (st_b && st_c));
		next_state = seq_state_t'({na, nb, nc});
		// strobe off forces the copy clear, matching idle
		next_delayed_byte_strobe = pins.lower_byte_strobe &&
			pins.address_strobe;
		if (!ce_i)
		begin
			next_state               = state;
			next_delayed_byte_strobe = delayed_byte_strobe;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			state               <= SEQ_IDLE;
			delayed_byte_strobe <= 1'b0;
		end
		else
		begin
			state               <= next_state;
			delayed_byte_strobe <= next_delayed_byte_strobe;
		end
	end

	// wait count: cycles of the current address strobe, saturating
	always_comb
	begin
		waits_needed  = wait_states(irq_acknowledge_cycle,
			pins.wait_count_select);
		next_wait_cnt = wait_cnt;
		if (ce_i)
		begin
			if (!pins.address_strobe)
				next_wait_cnt = 4'h0;
			else if (wait_cnt != CNT_MAX)
				next_wait_cnt = wait_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			wait_cnt <= 4'h0;
		else
			wait_cnt <= next_wait_cnt;
	end

	// strobe decode; outputs registered so pins are glitch free
	always_comb
	begin
		logic rd_byte;
		logic rd_short;
		logic rd_ack;
		logic rd_ext;
		rd_byte  = 1'b0;
		rd_short = 1'b0;
		rd_ack   = 1'b0;
		rd_ext   = 1'b0;
		// needing both copies delays the asserting edge by one clock
		rd_byte  = pins.lower_byte_strobe && delayed_byte_strobe &&
			pins.read_not_write && !irq_acknowledge_cycle;
		rd_short = !irq_acknowledge_cycle && !st_a && !st_b && st_c &&
			pins.wait_count_select;
		// acknowledge read ignores the byte strobe entirely
		rd_ack   = irq_acknowledge_cycle && st_a && !st_b;
		rd_ext   = pins.ack && pins.lower_byte_strobe;
		next_strobes.rd    = rd_byte || rd_short || rd_ack || rd_ext;
		next_strobes.wr    = pins.lower_byte_strobe && delayed_byte_strobe &&
			!pins.read_not_write && !irq_acknowledge_cycle;
		next_strobes.dtack = pins.address_strobe &&
			(wait_cnt >= (DTACK_BASE + waits_needed));
		next_irq_ack       = irq_acknowledge_cycle;
		if (!ce_i)
		begin
			next_strobes = strobes;
			next_irq_ack = irq_ack;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			strobes <= STROBES_RESET;
			irq_ack <= 1'b0;
		end
		else
		begin
			strobes <= next_strobes;
			irq_ack <= next_irq_ack;
		end
	end

	// pins are active low, strobes held active high internally
	assign peripheral_rd_n_o       = ~strobes.rd;
	assign peripheral_wr_n_o       = ~strobes.wr;
	assign dtack_n_o               = ~strobes.dtack;
	assign irq_acknowledge_cycle_o = irq_ack;
	assign seq_state_o             = state;

endmodule : cpu_peripheral_wait_state_glue

// ---- verification/glue_asserts.sv ----
`timescale 1ns/1ns
module glue_asserts (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	// processor pins
	input  wire logic       address_strobe_n_i,
	input  wire logic       lower_byte_strobe_n_i,
	input  wire logic       read_not_write_i,
	input  wire logic [2:0] cpu_function_code_i,
	input  wire logic       wait_count_select_i,
	input  wire logic       ack_n_i,
	// glue outputs
	input  wire logic       peripheral_rd_n_o,
	input  wire logic       peripheral_wr_n_o,
	input  wire logic       dtack_n_o,
	input  wire logic       irq_acknowledge_cycle_o,
	input  wire logic [2:0] seq_state_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	logic [2:0] ps;
	logic [2:0] d;
	wire        fc7 = cpu_function_code_i == 3'h7;
	wire  [2:0] s   = seq_state_o;

	// pins pass two sync flops, so the sequencer sees them three samples late
	always_ff @(posedge clk_sys_i)
	begin
		ps <= seq_state_o;
		d  <= {d[1:0], ~address_strobe_n_i};
	end

	state_a_a: assert property (
		s[2] == (ps[2] & ~ps[1] | ps[1] & ps[0] | ~d[2]))
		else $error("state bit a wrong");
	state_b_a: assert property (
		s[1] == (ps[2] & ~ps[0] | ~ps[2] & ps[0] | ~d[2]))
		else $error("state bit b wrong");
	state_c_a: assert property (
		s[0] == (d[2] & (~ps[2] & ~ps[1] | ps[1] & ps[0])))
		else $error("state bit c wrong");
	dtack_short_a: assert property (
		$fell(address_strobe_n_i) && wait_count_select_i && !fc7
		|-> dtack_n_o[*6] ##1 !dtack_n_o) else $error("one wait wrong");
	dtack_long_a: assert property (
		$fell(address_strobe_n_i) && !wait_count_select_i && !fc7
		|-> dtack_n_o[*7] ##1 !dtack_n_o) else $error("two waits wrong");
	dtack_irq_a: assert property (
		$fell(address_strobe_n_i) && fc7
		|-> ##3 dtack_n_o[*6] ##1 !dtack_n_o) else $error("four waits wrong");
	rd_read_a: assert property (
		$fell(address_strobe_n_i) && read_not_write_i && !fc7
		&& !lower_byte_strobe_n_i |-> peripheral_rd_n_o[*4]
		##1 !peripheral_rd_n_o) else $error("read strobe timing wrong");
	rd_irq_a: assert property (
		$fell(address_strobe_n_i) && fc7 && lower_byte_strobe_n_i && ack_n_i
		|-> ##1 peripheral_rd_n_o[*8] ##1 !peripheral_rd_n_o)
		else $error("vector strobe timing wrong");
	ack_byte_a: assert property (
		!ack_n_i && !lower_byte_strobe_n_i |-> ##3 !peripheral_rd_n_o)
		else $error("ack read strobe missing");
	wr_write_a: assert property (
		$fell(address_strobe_n_i) && !read_not_write_i && !fc7
		&& !lower_byte_strobe_n_i |-> peripheral_wr_n_o[*4]
		##1 !peripheral_wr_n_o) else $error("write strobe late");
	wr_quiet_a: assert property (
		$fell(address_strobe_n_i) && read_not_write_i
		|-> peripheral_wr_n_o[*8]) else $error("write strobe on a read");
	irq_flag_a: assert property (
		$fell(address_strobe_n_i) && fc7
		|-> !irq_acknowledge_cycle_o[*3] ##1 irq_acknowledge_cycle_o)
		else $error("acknowledge flag timing wrong");
	irq_quiet_a: assert property (
		$fell(address_strobe_n_i) && !fc7
		|-> !irq_acknowledge_cycle_o[*8])
		else $error("acknowledge flag without cycle");
endmodule : glue_asserts

bind cpu_peripheral_wait_state_glue glue_asserts u_chk (.*);

// ---- verification/cpu_bus_model.sv ----
`timescale 1ns/1ns
module cpu_bus_model (
	// clock and answers from the glue
	input  wire logic       clk_sys_i,
	input  wire logic       dtack_n_i,
	input  wire logic       rd_n_i,
	// processor bus pins
	output logic            addr_strobe_n_o,
	output logic            byte_strobe_n_o,
	output logic            rnw_o,
	output logic            wsel_o,
	output logic            ack_n_o,
	output logic [2:0]      fc_o
);
	// idle bus at time zero, strobes off
	initial
	begin
		addr_strobe_n_o = 1'b1;
		byte_strobe_n_o = 1'b1;
		rnw_o = 1'b1;
		wsel_o = 1'b1;
		ack_n_o = 1'b1;
		fc_o = 3'h0;
	end

	// one bus cycle; returns edges until dtack and first read strobe
	task automatic cycle(input int mhz, input logic r, input logic [2:0] f,
		input logic l, input logic a, output int t_ack, output int t_rd);
		int n;
		t_ack = 0;
		t_rd = 0;
		@(posedge clk_sys_i);
		wsel_o  <= (mhz == 4);
		rnw_o   <= r;
		fc_o    <= f;
		byte_strobe_n_o <= l;
		ack_n_o         <= a;
		addr_strobe_n_o <= 1'b0;
		for (n = 1; n < 30 && t_ack == 0; n++)
		begin
			@(posedge clk_sys_i);
			@(negedge clk_sys_i);
			if (!rd_n_i && t_rd == 0)
				t_rd = n;
			if (!dtack_n_i)
				t_ack = n;
		end
		// released lines flip so stale values never look valid
		@(posedge clk_sys_i);
		addr_strobe_n_o <= 1'b1;
		byte_strobe_n_o <= 1'b1;
		ack_n_o         <= 1'b1;
		fc_o    <= ~f;
		rnw_o   <= ~r;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : cycle
endmodule : cpu_bus_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
module testbench
	import glue_pkg::*;
;
	logic       clk_sys_i;
	logic       sys_rst_i;
	logic       addr_strobe_n;
	logic       byte_strobe_n;
	logic       rnw;
	logic       wsel;
	logic       ack_n;
	logic [2:0] fc;
	logic       rd_n;
	logic       dtack_n;
	logic [2:0] state;
	int         err_count = 0;
	int         num_checks = 0;
	int         cycles = 0;

	// device and processor model
	cpu_peripheral_wait_state_glue u_dut (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .ce_i(1'b1),
		.address_strobe_n_i(addr_strobe_n),
		.lower_byte_strobe_n_i(byte_strobe_n), .read_not_write_i(rnw),
		.cpu_function_code_i(fc), .wait_count_select_i(wsel),
		.ack_n_i(ack_n), .peripheral_rd_n_o(rd_n), .peripheral_wr_n_o(),
		.dtack_n_o(dtack_n), .irq_acknowledge_cycle_o(),
		.seq_state_o(state));
	cpu_bus_model u_cpu (.clk_sys_i(clk_sys_i), .dtack_n_i(dtack_n),
		.rd_n_i(rd_n), .addr_strobe_n_o(addr_strobe_n),
		.byte_strobe_n_o(byte_strobe_n), .rnw_o(rnw),
		.wsel_o(wsel), .ack_n_o(ack_n), .fc_o(fc));

	// clock and hang guard; eight accesses of under 40 edges each
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			err_count++;
			print_verdict();
		end
	end

	task automatic chk_int(input int got, input int exp);
		num_checks++;
		if (got != exp)
		begin
			err_count++;
			$display("MISMATCH %0t edges %0d not %0d", $time, got, exp);
		end
	endtask : chk_int

	task automatic chk_st(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t state %h not %h", $time, got, exp);
		end
	endtask : chk_st

	// edges to dtack and to the read strobe; 0 means no strobe
	task automatic run(input int mhz, input logic r, input logic [2:0] f,
		input logic l, input logic a, input int e_ack, input int e_rd);
		int t_ack;
		int t_rd;
		u_cpu.cycle(mhz, r, f, l, a, t_ack, t_rd);
		chk_int(t_ack, e_ack);
		chk_int(t_rd, e_rd);
		chk_st(state, SEQ_IDLE);
	endtask : run

	task automatic read_short;
		run(4, 1'b1, 3'h5, 1'b0, 1'b1, 6, 4);
	endtask : read_short
	task automatic read_long;
		run(8, 1'b1, 3'h5, 1'b0, 1'b1, 7, 4);
	endtask : read_long
	task automatic upper_short;
		run(4, 1'b1, 3'h5, 1'b1, 1'b1, 6, 6);
	endtask : upper_short
	task automatic upper_long;
		run(10, 1'b1, 3'h6, 1'b1, 1'b1, 7, 0);
	endtask : upper_long
	task automatic write_only;
		run(6, 1'b0, 3'h5, 1'b0, 1'b1, 7, 0);
	endtask : write_only
	task automatic ack_write;
		run(6, 1'b0, 3'h5, 1'b0, 1'b0, 7, 3);
	endtask : ack_write
	task automatic irq_short;
		run(4, 1'b1, 3'h7, 1'b1, 1'b1, 9, 9);
	endtask : irq_short
	task automatic irq_long;
		run(8, 1'b1, 3'h7, 1'b0, 1'b1, 9, 9);
	endtask : irq_long

	task automatic print_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// reset, then every access kind back to back
	initial
	begin
		sys_rst_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		read_short();
		read_long();
		upper_short();
		upper_long();
		write_only();
		ack_write();
		irq_short();
		irq_long();
		print_verdict();
	end
endmodule : testbench
